// file: rtl/gbd_consts.vh
/*
  Constants of the graphics bus DMA: field positions, reset values, timing counts and sizes.
  Assumes inclusion by bare name from the design files.
*/
`ifndef GBD_CONSTS_VH
`define GBD_CONSTS_VH

// ==========================================================
// Control/status bit positions (written and read as loose bits)
`define GBD_CS_BSY      0
`define GBD_CS_STP      1
`define GBD_CS_DCC      2
`define GBD_CS_DSI      3
`define GBD_CS_DTA      4

// ==========================================================
// Reset values
`define GBD_WS_RST      3'h0
`define GBD_PTR_RST     24'h000000

// ==========================================================
// Timing and sizes
`define GBD_CWH_CYC     10'h002
`define GBD_FIFO_DEPTH  16
`define GBD_ADDR_W      24

`endif

// file: rtl/gbd_dma.v
/*
  Graphics bus DMA engine with a 16-word FIFO between memory reads and the
  external parallel port, plus timed CPU writes and reads of external registers.
  Assumes a single clock, a memory that answers mem_req with mem_ack and data, and
  an interrupt controller that reports interrupt entry and exit as pulses.
*/
`timescale 1ns/10ps
`include "gbd_consts.vh"

// ==========================================================
// FIFO
module gbd_fifo #(
  parameter W = 8,
  parameter D = `GBD_FIFO_DEPTH,
  parameter AW = 4
) (
  input  wire         clk,
  input  wire         rst_b,
  input  wire         ce,
  input  wire         flush,
  input  wire [W-1:0] in_data,
  input  wire         in_valid,
  output wire         in_ready,
  output wire [W-1:0] out_data,
  output wire         out_valid,
  input  wire         out_ready
);
  reg  [W-1:0] mem_r [0:D-1];
  reg  [AW-1:0] wp_r;
  reg  [AW-1:0] rp_r;
  reg  [AW:0]   cnt_r;
  wire          wr = in_valid && in_ready;
  wire          rd = out_valid && out_ready;
  assign in_ready  = (cnt_r != D[AW:0]);
  assign out_valid = (cnt_r != {(AW+1){1'b0}});
  assign out_data  = mem_r[rp_r];
  always @(posedge clk)
  begin
    if (!rst_b || (ce && flush))
    begin
      wp_r  <= {AW{1'b0}};
      rp_r  <= {AW{1'b0}};
      cnt_r <= {(AW+1){1'b0}};
    end
    else if (ce)
    begin
      if (wr)
      begin
        mem_r[wp_r] <= in_data;
        wp_r        <= wp_r + 1'b1;
      end
      if (rd)
        rp_r <= rp_r + 1'b1;
      if (wr && !rd)
        cnt_r <= cnt_r + 1'b1;
      else if (rd && !wr)
        cnt_r <= cnt_r - 1'b1;
    end
  end
endmodule

// ==========================================================
// Engine
//
// Contract
// (RULE_01) Three modes: block write, timed CPU write, timed CPU read.
// (RULE_02) Block spans up to 16 MB, any byte alignment, no bank limit.
// (RULE_03) Software writes start bytes high to low, then end bytes, low end last.
// (RULE_04) Writing the low end pointer byte starts the block transfer at once.
// (RULE_05) Source pointer is a 24-bit physical address.
// (RULE_06) CPU bus cycles wait while the engine holds a memory cycle.
// (RULE_07) Transfer-active stays set from request until transfer fully done.
// (RULE_08) Busy flag set only while engine runs, clear while halted; code also sets it during CPU writes and memory fetches.
// (RULE_09) Control bits stop and restart; interrupts may halt and resume.
// (RULE_10) Reaching end address stops engine and pulses interrupt output.
// (RULE_11) Each block byte appears on 8-bit data port with write strobe.
// (RULE_12) Each CPU data write makes exactly one external write cycle.
// (RULE_13) Rewrite before previous write ends stalls CPU with waits.
// (RULE_14) Each CPU data read makes one external read cycle with read strobe.
// (RULE_15) CPU read stalls until external read completes, returns external data.
// (RULE_16) External cycle time selectable from clock/2 to clock/256.
// (RULE_17) Busy reads set while a CPU external write is in progress.
// (RULE_18) A flag records CPU conflicts with the running engine.
// (RULE_19) Wait field codes 0 to 7 give 2 to 256 wait states.
// (RULE_20) Equal start and end pointers stop engine and refuse start.
// (RULE_21) Conflict set on CPU port register access while active; cleared by zero write.
// (RULE_22) With stall option, first nested interrupt stops, outermost end restarts.
// (RULE_23) Source pointer advances by one after each byte.
// (RULE_24) Pointer and configuration writes while busy need not be honoured.
module gbd_dma #(
  parameter AW = `GBD_ADDR_W
) (
  input  wire          clk,
  input  wire          rst_b,
  input  wire          ce,
  input  wire [2:0]    wait_state_select,
  input  wire          cpu_wait_enable,
  input  wire          cfg_we,
  input  wire [7:0]    ptr_wdata,
  input  wire [5:0]    ptr_we,
  input  wire          stop_request_bit,
  input  wire          start_request,
  input  wire          stall_opt_wdata,
  input  wire          stall_opt_we,
  input  wire          conflict_clr,
  input  wire          int_enter,
  input  wire          int_exit,
  input  wire          port_reg_access,
  input  wire          cpu_bus_req,
  input  wire          port_wr,
  input  wire          port_rd,
  input  wire [7:0]    port_wdata,
  output reg           mem_req,
  output reg  [AW-1:0] mem_addr,
  input  wire          mem_ack,
  input  wire [7:0]    mem_rdata,
  output reg  [7:0]    ext_data_bus,
  output reg           ext_data_oe,
  input  wire [7:0]    ext_data_in,
  output reg           ext_write_strobe,
  output reg           ext_read_strobe,
  output reg           cpu_wait,
  output reg  [7:0]    port_rdata,
  output reg           transfer_active_flag,
  output reg           engine_busy_flag,
  output reg           cpu_conflict_flag,
  output reg           stall_opt,
  output reg  [AW-1:0] start_ptr,
  output reg           done_irq
);
  localparam S_IDLE = 3'b001;
  localparam S_LOW  = 3'b010;
  localparam S_HIGH = 3'b100;

  // Strobe active low in idle-high convention is avoided; strobes here are active high
  function [8:0] half_cycles;
    input [2:0] ws;
    begin
      half_cycles = 9'h001 << ws; // [RULE_19] [RULE_16]
    end
  endfunction

  reg  [2:0]    ws_r;
  reg           wsa_r;
  reg  [AW-1:0] src_r;
  reg  [AW-1:0] end_r;
  reg           run_r;
  reg           dta_r;
  reg           ihalt_r;
  reg  [3:0]    nest_r;
  reg  [2:0]    st_r;
  reg  [9:0]    tmr_r;
  reg           cpu_op_r;
  reg           rd_op_r;
  reg           fetch_r;
  reg           fetch_done_r;
  reg  [7:0]    wdat_r;
  wire [7:0]    f_data;
  wire          f_valid;
  wire          f_in_ready;
  wire          ptr_eq   = (src_r == end_r);
  wire          running  = run_r && !ihalt_r && !ptr_eq;
  wire          bus_idle = (st_r == S_IDLE);
  wire          f_take   = bus_idle && !cpu_op_r && f_valid;
  wire          cpu_go   = bus_idle && cpu_op_r;
  wire          restart;
  wire [AW-1:0] end_nxt  = {ptr_we[5] ? ptr_wdata : end_r[23:16],
                            ptr_we[4] ? ptr_wdata : end_r[15:8],
                            ptr_we[0] ? ptr_wdata : end_r[7:0]};
  // A fresh end byte is judged against the new end, not the stale one
  assign restart = (ptr_we[0] && (end_nxt != src_r)) || (start_request && !ptr_eq);

  gbd_fifo #(.W(8), .D(`GBD_FIFO_DEPTH), .AW(4)) u_fifo (
    .clk       (clk),
    .rst_b     (rst_b),
    .ce        (ce),
    .flush     (restart && !dta_r),
    .in_data   (mem_rdata),
    .in_valid  (fetch_r && mem_ack),
    .in_ready  (f_in_ready),
    .out_data  (f_data),
    .out_valid (f_valid),
    .out_ready (f_take)
  );

  always @(posedge clk)
  begin
    if (!rst_b)
    begin
      ws_r <= `GBD_WS_RST;
      wsa_r <= 1'b0;
      src_r <= `GBD_PTR_RST;
      end_r <= `GBD_PTR_RST;
      run_r <= 1'b0;
      dta_r <= 1'b0;
      ihalt_r <= 1'b0;
      nest_r <= 4'h0;
      st_r <= S_IDLE;
      tmr_r <= 10'h000;
      cpu_op_r <= 1'b0;
      rd_op_r <= 1'b0;
      fetch_r <= 1'b0;
      fetch_done_r <= 1'b0;
      wdat_r <= 8'h00;
      mem_req <= 1'b0;
      mem_addr <= `GBD_PTR_RST;
      ext_data_bus <= 8'h00;
      ext_data_oe <= 1'b0;
      ext_write_strobe <= 1'b0;
      ext_read_strobe <= 1'b0;
      cpu_wait <= 1'b0;
      port_rdata <= 8'h00;
      transfer_active_flag <= 1'b0;
      engine_busy_flag <= 1'b0;
      cpu_conflict_flag <= 1'b0;
      stall_opt <= 1'b0;
      start_ptr <= `GBD_PTR_RST;
      done_irq <= 1'b0;
    end
    else if (ce)
    begin
      done_irq <= 1'b0;
      // Configuration is ignored while the engine is busy
      if (cfg_we && !engine_busy_flag) // [RULE_24]
      begin
        ws_r  <= wait_state_select;
        wsa_r <= cpu_wait_enable;
      end
      if (stall_opt_we && !dta_r)
        stall_opt <= stall_opt_wdata;
      if (!engine_busy_flag) // [RULE_24] [RULE_03]
      begin
        if (ptr_we[3]) src_r[23:16] <= ptr_wdata;
        if (ptr_we[2]) src_r[15:8]  <= ptr_wdata;
        if (ptr_we[1]) src_r[7:0]   <= ptr_wdata;
        end_r <= end_nxt;
      end
      // Interrupt nesting; only the first entry and the outermost exit count
      if (int_enter && !int_exit)
      begin
        nest_r <= nest_r + 4'h1;
        if (nest_r == 4'h0 && stall_opt && run_r) ihalt_r <= 1'b1; // [RULE_22]
      end
      else if (int_exit && !int_enter && nest_r != 4'h0)
      begin
        nest_r <= nest_r - 4'h1;
        if (nest_r == 4'h1) ihalt_r <= 1'b0; // [RULE_22] [RULE_09]
      end
      // Start, stop and completion
      if (stop_request_bit)
        run_r <= 1'b0; // [RULE_09]
      else if ((ptr_we[0] && (end_nxt != src_r)) || (start_request && !ptr_eq))
      begin
        run_r <= 1'b1; // [RULE_04] [RULE_09] [RULE_20]
        dta_r <= 1'b1;
      end
      // Memory fetch into the FIFO, 24-bit physical pointer
      if (fetch_r)
      begin
        if (mem_ack)
        begin
          fetch_r <= 1'b0;
          mem_req <= 1'b0;
          src_r   <= src_r + 24'h000001; // [RULE_23] [RULE_02] [RULE_05]
          if (src_r + 24'h000001 == end_r) fetch_done_r <= 1'b1;
        end
      end
      else if (running && f_in_ready && !fetch_done_r && !stop_request_bit)
      begin
        fetch_r  <= 1'b1;
        mem_req  <= 1'b1;
        mem_addr <= src_r; // [RULE_05]
      end
      // Completion once the last byte has left the port
      if (dta_r && fetch_done_r && !f_valid && bus_idle && !fetch_r)
      begin
        dta_r <= 1'b0;
        run_r <= 1'b0;
        fetch_done_r <= 1'b0;
        done_irq <= 1'b1; // [RULE_10]
      end
      // The stale end equals the source when only the end is rewritten
      if (ptr_eq && !fetch_done_r && !fetch_r && !ptr_we[0])
        run_r <= 1'b0; // [RULE_20]
      // CPU access requests
      if ((port_wr || port_rd) && wsa_r && !cpu_op_r)
      begin
        cpu_op_r <= 1'b1; // [RULE_01]
        rd_op_r  <= port_rd;
        wdat_r   <= port_wdata;
      end
      // External bus sequencer: block writes take two equal phases, CPU writes a fixed 2-cycle high phase, reads a double low phase only
      case (st_r)
        S_IDLE:
        begin
          if (cpu_go)
          begin
            st_r <= S_LOW;
            tmr_r <= rd_op_r ? {half_cycles(ws_r), 1'b0} : {1'b0, half_cycles(ws_r)};
            ext_data_oe <= !rd_op_r;
            ext_data_bus <= wdat_r;
            ext_write_strobe <= !rd_op_r; // [RULE_12]
            ext_read_strobe <= rd_op_r; // [RULE_14]
          end
          else if (f_take)
          begin
            st_r <= S_LOW;
            tmr_r <= {1'b0, half_cycles(ws_r)};
            ext_data_oe <= 1'b1;
            ext_data_bus <= f_data; // [RULE_11]
            ext_write_strobe <= 1'b1;
          end
        end
        S_LOW:
        begin
          if (tmr_r == 10'h001)
          begin
            ext_write_strobe <= 1'b0;
            ext_read_strobe <= 1'b0;
            if (rd_op_r && cpu_op_r)
            begin
              port_rdata <= ext_data_in; // [RULE_15]
              st_r <= S_IDLE;
              cpu_op_r <= 1'b0;
            end
            else
            begin
              st_r <= S_HIGH;
              tmr_r <= cpu_op_r ? `GBD_CWH_CYC : {1'b0, half_cycles(ws_r)};
            end
          end
          else
            tmr_r <= tmr_r - 10'h001;
        end
        S_HIGH:
        begin
          if (tmr_r == 10'h001)
          begin
            st_r <= S_IDLE;
            cpu_op_r <= 1'b0;
          end
          else
            tmr_r <= tmr_r - 10'h001;
        end
        default:
          st_r <= S_IDLE;
      endcase
      // CPU stalls: pending or repeated external access, or memory cycle stolen
      cpu_wait <= (cpu_bus_req && fetch_r) // [RULE_06]
                  || (wsa_r && (port_rd || (port_wr && cpu_op_r))) // [RULE_13] [RULE_15]
                  || (cpu_op_r && rd_op_r && !(st_r == S_LOW && tmr_r == 10'h001));
      // Conflict: set wins over the clear
      if (port_reg_access && dta_r)
        cpu_conflict_flag <= 1'b1; // [RULE_18] [RULE_21]
      else if (conflict_clr)
        cpu_conflict_flag <= 1'b0; // [RULE_21]
      transfer_active_flag <= dta_r || restart; // [RULE_07]
      engine_busy_flag <= (running || fetch_r) || (cpu_op_r && !rd_op_r); // [RULE_08] [RULE_17]
      start_ptr <= src_r;
    end
  end
endmodule

// file: sim/gbd_chk.sv
/*
  Checker for gbd_dma, bound to its ports.
  Assumes one clock and a synchronous reset, low while rst_b is 0.
*/
`timescale 1ns/10ps
// ==========================================
// Checker
module gbd_chk #(
  parameter AW = 24
) (
  input wire          clk,
  input wire          rst_b,
  input wire [2:0]    wait_state_select,
  input wire          cfg_we,
  input wire [7:0]    ptr_wdata,
  input wire [5:0]    ptr_we,
  input wire          start_request,
  input wire          int_exit,
  input wire          port_reg_access,
  input wire          cpu_bus_req,
  input wire          mem_req,
  input wire          ext_write_strobe,
  input wire          ext_read_strobe,
  input wire          cpu_wait,
  input wire          transfer_active_flag,
  input wire          engine_busy_flag,
  input wire          cpu_conflict_flag,
  input wire [AW-1:0] start_ptr,
  input wire          done_irq
);
  reg [2:0]  ws_r;
  reg [23:0] end_r;
  reg [9:0]  hc_r;
  reg [9:0]  rc_r;
  // Shadow copies follow the design's rule that busy blocks writes
  always @(posedge clk)
  begin
    hc_r <= ext_write_strobe ? hc_r + 10'h1 : 10'h0;
    rc_r <= ext_read_strobe ? rc_r + 10'h1 : 10'h0;
    if (!rst_b)
    begin
      ws_r <= 3'h0;
      end_r <= 24'h000000;
    end
    else if (!engine_busy_flag)
    begin
      if (cfg_we) ws_r <= wait_state_select;
      if (ptr_we[0]) end_r[7:0] <= ptr_wdata;
      if (ptr_we[4]) end_r[15:8] <= ptr_wdata;
      if (ptr_we[5]) end_r[23:16] <= ptr_wdata;
    end
  end
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_b);
  sequence s_quiet;
    !done_irq && !transfer_active_flag;
  endsequence
  property p_start;
    $rose(transfer_active_flag) |-> $past(ptr_we[0]) || $past(start_request) || $past(int_exit);
  endproperty
  a_start: assert property (p_start) else $error("transfer began unrequested");
  property p_done;
    done_irq |=> s_quiet;
  endproperty
  a_done: assert property (p_done) else $error("done pulse too long or flag stuck");
  property p_end;
    done_irq |-> start_ptr == end_r;
  endproperty
  a_end: assert property (p_end) else $error("pointer not at end on completion");
  property p_ref;
    ptr_we[0] && !transfer_active_flag && {end_r[23:8], ptr_wdata} == start_ptr |=> !transfer_active_flag;
  endproperty
  a_ref: assert property (p_ref) else $error("start with equal pointers");
  property p_wr;
    $fell(ext_write_strobe) |-> hc_r == (10'h1 << ws_r);
  endproperty
  a_wr: assert property (p_wr) else $error("write strobe width");
  property p_rd;
    $fell(ext_read_strobe) |-> rc_r == (10'h2 << ws_r);
  endproperty
  a_rd: assert property (p_rd) else $error("read strobe width");
  property p_dcc;
    port_reg_access && transfer_active_flag |=> cpu_conflict_flag;
  endproperty
  a_dcc: assert property (p_dcc) else $error("conflict not flagged");
  property p_cw;
    mem_req && cpu_bus_req |-> ##[0:2] cpu_wait;
  endproperty
  a_cw: assert property (p_cw) else $error("cpu not held");
endmodule
bind gbd_dma gbd_chk #(.AW(AW)) u_chk (.*);

// file: sim/gbd_disp.sv
/*
  Model of the external display chip on the parallel port.
  Assumes active-high strobes and one clock.
*/
`timescale 1ns/10ps
// ==========================================
// Display chip
module gbd_disp (
  input wire        clk,
  input wire [7:0]  ext_data_bus,
  input wire        ext_write_strobe,
  input wire        ext_read_strobe,
  input wire [7:0]  rd_val,
  output wire [7:0] ext_data_in,
  output reg        cap,
  output reg [7:0]  cap_d
);
  reg pw = 1'b0;
  // Inverse outside a read so a stale latch cannot pass
  assign ext_data_in = ext_read_strobe ? rd_val : ~rd_val;
  always @(posedge clk)
  begin
    pw <= ext_write_strobe;
    cap <= ext_write_strobe && !pw;
    cap_d <= ext_data_bus;
  end
endmodule

// file: sim/gbd_dma_tb_top.sv
/*
  Testbench of gbd_dma with memory and display models.
  Assumes the checker is bound by its own file.
*/
`timescale 1ns/10ps
// ==========================================
// Bench
module gbd_dma_tb_top;
  reg clk = 1'b0, rst_b = 1'b0, cpu_wait_enable = 1'b0, port_wr = 1'b0, port_rd = 1'b0;
  reg mem_ack = 1'b0, cpu_bus_req = 1'b0;
  reg [2:0] wait_state_select = 3'h0;
  reg [5:0] ptr_we = 6'h00;
  reg [7:0] ptr_wdata = 8'h00, port_wdata = 8'h00, mem_rdata = 8'h00, rd_val = 8'h00, pv = 8'h00, v;
  reg [31:0] rs = 32'hda76bd64;
  reg [23:0] irq_n = 24'h0, rd_n = 24'h0, wn = 24'h0, n, mismatches = 24'h0, checks_done = 24'h0;
  reg [1:0] md = 2'h0;
  reg prs = 1'b0;
  reg [7:0] eq [$];
  integer k, t = 0;
  wire ce = 1'b1, stall_opt_wdata = 1'b1;
  wire cfg_we, stop_request_bit, start_request, stall_opt_we, port_reg_access, conflict_clr, int_enter, int_exit;
  wire mem_req, ext_data_oe, ext_write_strobe, ext_read_strobe, cpu_wait, transfer_active_flag;
  wire engine_busy_flag, cpu_conflict_flag, stall_opt, done_irq, cap;
  wire [23:0] mem_addr, start_ptr;
  wire [7:0] ext_data_bus, ext_data_in, port_rdata, cap_d;
  assign {int_exit, int_enter, conflict_clr, port_reg_access, stall_opt_we, start_request, stop_request_bit, cfg_we} = pv;
  gbd_dma DUT (.*);
  gbd_disp u_disp (.*);
  function [31:0] nx(input [31:0] x);
    nx = {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction
  function [7:0] mf(input [23:0] a);
    mf = a[7:0] ^ a[15:8] ^ a[23:16] ^ 8'h3c;
  endfunction
  initial forever #5 clk = ~clk;
  // Memory answers after a random delay; the counters feed the checks
  always @(posedge clk)
  begin
    rs <= nx(rs);
    mem_ack <= 1'b0;
    cpu_bus_req <= rs[5];
    prs <= ext_read_strobe;
    irq_n <= irq_n + done_irq;
    wn <= wn + cpu_wait;
    if (ext_read_strobe && !prs) rd_n <= rd_n + 24'h1;
    if (mem_req && !mem_ack)
    begin
      if (md == 2'h0)
      begin
        mem_ack <= 1'b1;
        mem_rdata <= mf(mem_addr);
        md <= rs[1:0];
      end
      else
        md <= md - 2'h1;
    end
    if (cap) cmp(eq.size() ? eq.pop_front() : 8'hee, cap_d);
  end
  task cmp(input [23:0] e, input [23:0] g);
  begin
    checks_done = checks_done + 24'h1;
    if (g !== e)
    begin
      mismatches = mismatches + 24'h1;
      $display("wrong value at %0t: expected %h got %h", $time, e, g);
    end
  end
  endtask
  task tk(input integer c);
    repeat (c) @(posedge clk);
  endtask
  task pl(input [7:0] m);
  begin
    @(posedge clk);
    pv <= m;
    @(posedge clk);
    pv <= 8'h00;
  end
  endtask
  task wp(input [5:0] m, input [7:0] d);
  begin
    @(posedge clk);
    ptr_we <= m;
    ptr_wdata <= d;
    @(posedge clk);
    ptr_we <= 6'h00;
  end
  endtask
  task cf(input [2:0] w, input a);
  begin
    wait_state_select <= w;
    cpu_wait_enable <= a;
    pl(8'h01);
  end
  endtask
  task run(input [23:0] s, input [23:0] e);
    reg [23:0] a;
  begin
    wp(6'h08, s[23:16]);
    wp(6'h04, s[15:8]);
    wp(6'h02, s[7:0]);
    wp(6'h20, e[23:16]);
    wp(6'h10, e[15:8]);
    for (a = s; a != e; a = a + 24'h1) eq.push_back(mf(a));
    wp(6'h01, e[7:0]);
  end
  endtask
  task cw(input [7:0] d);
  begin
    @(posedge clk);
    port_wr <= 1'b1;
    port_wdata <= d;
    eq.push_back(d);
    @(posedge clk);
    #1;
    while (cpu_wait === 1'b1)
    begin
      @(posedge clk);
      #1;
    end
    @(posedge clk);
    port_wr <= 1'b0;
  end
  endtask
  task idle;
    integer i;
  begin
    tk(2);
    for (i = 0; i < 9000 && (transfer_active_flag | engine_busy_flag | cpu_wait) !== 1'b0; i = i + 1) tk(1);
    tk(3);
    cmp(0, eq.size());
    t = t + 1;
    $display("test %0d done", t);
  end
  endtask
  task end_sim;
  begin
    $display("checks %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 24'h0 && checks_done > 24'h0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  end
  endtask
  initial
  begin
    tk(20000);
    mismatches = mismatches + 24'h1;
    end_sim;
  end
  initial
  begin
    tk(16);
    rst_b <= 1'b1;
    tk(1);
    cmp(0, {transfer_active_flag, engine_busy_flag, cpu_conflict_flag, done_irq, stall_opt, start_ptr});
    idle;
    cf(3'h0, 1'b0);
    run(24'h00fffe, 24'h010003);
    tk(1);
    cmp(1, transfer_active_flag);
    idle;
    cmp(24'h010003, start_ptr);
    cmp(1, irq_n);
    wp(6'h01, 8'h03);
    tk(2);
    cmp(0, transfer_active_flag);
    pl(8'h04);
    tk(2);
    cmp(0, engine_busy_flag);
    cf(3'h2, 1'b0);
    pl(8'h08);
    tk(1);
    cmp(1, stall_opt);
    run(24'h010003, 24'h010043);
    tk(8);
    pl(8'h10);
    tk(1);
    cmp(1, cpu_conflict_flag);
    pl(8'h20);
    tk(1);
    cmp(0, cpu_conflict_flag);
    pl(8'h02);
    tk(150);
    cmp(1, {engine_busy_flag, transfer_active_flag});
    pl(8'h04);
    tk(2);
    cmp(1, engine_busy_flag);
    pl(8'h40);
    pl(8'h40);
    tk(150);
    cmp(0, engine_busy_flag);
    pl(8'h80);
    tk(150);
    cmp(0, engine_busy_flag);
    pl(8'h80);
    tk(2);
    cmp(1, engine_busy_flag);
    idle;
    cmp(24'h010043, start_ptr);
    cmp(2, irq_n);
    cf(3'h1, 1'b1);
    n = wn;
    cw(rs[7:0]);
    cw(rs[15:8]);
    tk(1);
    cmp(1, engine_busy_flag);
    idle;
    cmp(1, wn > n);
    for (k = 0; k < 8; k = k + 1)
    begin
      cf(k[2:0], 1'b1);
      v = rs[7:0];
      rd_val <= v;
      n = rd_n;
      @(posedge clk);
      port_rd <= 1'b1;
      @(posedge clk);
      port_rd <= 1'b0;
      idle;
      cmp(v, port_rdata);
      cmp(n + 24'h1, rd_n);
    end
    end_sim;
  end
endmodule
